// ### bench/gatvr_host.sv
`timescale 1ns/1ps
// Host controller: one strobe per access, bus turned over when released
module gatvr_host
   import gatvr_pkg::*;
(
   input  wire logic       clk,
   output logic      [7:0] regAddr,
   output logic            regWrEn,
   output logic      [7:0] regWrData,
   output logic            regRdEn
);
   initial begin
      regAddr   = 8'h00;
      regWrEn   = 1'b0;
      regWrData = 8'h00;
      regRdEn   = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      #1;
      {regAddr, regWrData, regWrEn} = {a, d, 1'b1};
      @(posedge clk);
      #1;
      {regAddr, regWrData, regWrEn} = {~a, ~d, 1'b0};
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      #1;
      {regAddr, regRdEn} = {a, 1'b1};
      @(posedge clk);
      #1;
      {regAddr, regRdEn} = {~a, 1'b0};
   endtask : rd
   // Alignment set-up; noise-gate alignment goes on with either alignment
   task automatic align(input logic [7:0] cfg, input logic [7:0] mask);
      wr(ALIGN_CFG_OFS, cfg);
      wr(ALIGN_MASK_OFS, mask);
      wr(DIAG_CFG_OFS, {cfg[7] | cfg[0], 7'h0D});
   endtask : align
endmodule : gatvr_host

// ### bench/gatvr_regs_assertions.sv
`timescale 1ns/1ps
// Port-level checker for the configuration register group
module gatvr_regs_assertions
   import gatvr_pkg::*;
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [7:0] regAddr,
   input wire logic       regWrEn,
   input wire logic [7:0] regWrData,
   input wire logic       regRdEn,
   input wire logic [7:0] regRdData,
   input wire logic       pinGainAlign,
   input wire logic       pinGpOutput,
   input wire logic       audioTxEnable,
   input wire logic [4:0] audioSlotBits,
   input wire logic [5:0] audioSlot,
   input wire logic       brownoutAlignEnable,
   input wire logic       limiterAlignEnable,
   input wire logic [5:0] alignStartSlot,
   input wire logic       slotInLimiterGroup,
   input wire logic       diagClockExternal,
   input wire logic       diagActive,
   input wire logic [4:0] diagSignalSelect,
   input wire logic [7:0] brownoutAtten,
   input wire logic [7:0] limiterAtten,
   input wire logic [8:0] appliedAtten,
   input wire logic [7:0] volumeAttenHalfDb,
   input wire logic       volumeMute
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // ------------------------------------------------------------
   // Derived outputs two edges after a write
   // ------------------------------------------------------------
   sequence s_wrote(logic [7:0] ofs);
      $past(regWrEn, 2) && $past(regAddr, 2) == ofs;
   endsequence
   property p_pin_role;
      s_wrote(PIN_FUNC_OFS) |-> pinGainAlign == (($past(regWrData, 2) & 8'h1C) == 8'h00)
         && pinGpOutput == (($past(regWrData, 2) & 8'h1C) == 8'h10);
   endproperty
   a_pin_role: assert property (p_pin_role) else $error("pin role decode wrong");
   property p_slot_len;
      s_wrote(AUDIO_SLOT_OFS) |-> audioSlotBits == ($past(regWrData[7], 2) ? 5'h18 : 5'h10);
   endproperty
   a_slot_len: assert property (p_slot_len) else $error("slot length wrong");
   property p_tx_slot;
      s_wrote(AUDIO_SLOT_OFS) |-> {audioTxEnable, audioSlot} == $past(regWrData[6:0], 2);
   endproperty
   a_tx_slot: assert property (p_tx_slot) else $error("audio slot wrong");
   property p_brown;
      s_wrote(ALIGN_CFG_OFS) |-> brownoutAlignEnable == $past(regWrData[7], 2);
   endproperty
   a_brown: assert property (p_brown) else $error("brownout align wrong");
   property p_start;
      s_wrote(ALIGN_CFG_OFS) |-> alignStartSlot == $past(regWrData[6:1], 2);
   endproperty
   a_start: assert property (p_start) else $error("start slot wrong");
   property p_lim_en;
      slotInLimiterGroup |-> limiterAlignEnable;
   endproperty
   a_lim_en: assert property (p_lim_en) else $error("group hit while off");
   property p_diag_clk;
      s_wrote(DIAG_CFG_OFS) |-> diagClockExternal == $past(regWrData[6], 2);
   endproperty
   a_diag_clk: assert property (p_diag_clk) else $error("diag clock wrong");
   property p_combine;
      s_wrote(DIAG_CFG_OFS) |-> appliedAtten == ($past(regWrData[5], 2) ?
         (($past(brownoutAtten) > $past(limiterAtten)) ? {1'b0, $past(brownoutAtten)} :
         {1'b0, $past(limiterAtten)}) : {1'b0, $past(brownoutAtten)} + {1'b0, $past(limiterAtten)});
   endproperty
   a_combine: assert property (p_combine) else $error("attenuation wrong");
   // ------------------------------------------------------------
   // Standing relations and read-back
   // ------------------------------------------------------------
   property p_diag_sig;
      (diagActive == (diagSignalSelect != 5'h00)) && (diagSignalSelect < DIAG_RSVD_FIRST);
   endproperty
   a_diag_sig: assert property (p_diag_sig) else $error("diag select wrong");
   property p_volume;
      volumeMute == (volumeAttenHalfDb > VOLUME_MAX_CODE);
   endproperty
   a_volume: assert property (p_volume) else $error("mute wrong");
   property p_rsvd;
      regRdEn && regAddr == PIN_FUNC_OFS |=> (regRdData & 8'hE3) == 8'h00;
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
   c_group: cover property (slotInLimiterGroup);
   c_mute: cover property (volumeMute);
   c_align: cover property (regWrEn && regAddr == ALIGN_CFG_OFS);
endmodule : gatvr_regs_assertions

// ### bench/testbench.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
   $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module testbench
   import gatvr_pkg::*;
;
   logic       clk, rstn, regWrEn, regRdEn, slotInLimiterGroup, volumeMute;
   logic       pinGainAlign, pinBuffersOff, pinGpInput, pinGpOutput, audioTxEnable;
   logic       brownoutAlignEnable, limiterAlignEnable, alignNoiseGateEnable;
   logic       diagClockExternal, diagActive;
   logic [4:0] audioSlotBits, diagSignalSelect;
   logic [5:0] audioSlot, alignStartSlot, slotQuery;
   logic [7:0] regAddr, regWrData, regRdData, brownoutAtten, limiterAtten, volumeAttenHalfDb, d;
   logic [8:0] appliedAtten;
   logic [31:0] seed = 32'h00006FA0;
   logic [7:0] expQ[$];
   logic [7:0] expRd;
   logic [7:0] rstTbl[7] = '{8'h00, 8'h12, 8'h0C, 8'h00, 8'h0D, 8'h00, 8'h00};
   logic [7:0] volTbl[5] = '{8'h00, 8'hC7, 8'hC8, 8'hC9, 8'hFF};
   int         miscompares = 0, checked = 0;
   gatvr_host gatvr_host_inst (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn));
   gatvr_regs gatvr_regs_inst (.clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrEn(regWrEn),
      .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
      .pinGainAlign(pinGainAlign), .pinBuffersOff(pinBuffersOff), .pinGpInput(pinGpInput),
      .pinGpOutput(pinGpOutput), .audioTxEnable(audioTxEnable), .audioSlotBits(audioSlotBits),
      .audioSlot(audioSlot), .brownoutAlignEnable(brownoutAlignEnable),
      .limiterAlignEnable(limiterAlignEnable), .alignStartSlot(alignStartSlot),
      .alignNoiseGateEnable(alignNoiseGateEnable), .slotQuery(slotQuery),
      .slotInLimiterGroup(slotInLimiterGroup), .diagClockExternal(diagClockExternal),
      .diagActive(diagActive), .diagSignalSelect(diagSignalSelect),
      .brownoutAtten(brownoutAtten), .limiterAtten(limiterAtten), .appliedAtten(appliedAtten),
      .volumeAttenHalfDb(volumeAttenHalfDb), .volumeMute(volumeMute));
   always #5 clk = ~clk;
   function automatic logic [7:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[7:0];
   endfunction : xs
   task automatic settle();
      @(posedge clk);
      #1;
   endtask : settle
   task automatic rdx(input logic [7:0] a, input logic [7:0] e);
      expQ.push_back(e);
      gatvr_host_inst.rd(a);
   endtask : rdx
   task automatic tally_and_finish();
      // A read whose note was never taken counts as a miss
      if (expQ.size() != 0) begin
         miscompares++;
      end
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : tally_and_finish
   // Read data lands on the edge that takes the strobe
   always @(posedge clk) begin
      if (regRdEn === 1'b1) begin
         #2;
         expRd = expQ.pop_front();
         `CHK(regRdData, expRd)
      end
   end
   initial begin
      #100000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      {clk, rstn, slotQuery, brownoutAtten, limiterAtten} = '0;
      repeat (4) @(posedge clk);
      #1 rstn = 1'b1;
      `CHK({pinGainAlign, audioSlotBits, audioSlot}, {1'b1, SLOT_LEN_SHORT, 6'h12})
      for (int i = 0; i < 7; i++) rdx(8'(8'h15 + i), rstTbl[i]);
      for (int c = 0; c < 8; c++) begin
         gatvr_host_inst.wr(PIN_FUNC_OFS, 8'hE3 | 8'(c << 2));
         settle();
         `CHK({pinGainAlign, pinBuffersOff, pinGpInput, pinGpOutput},
            {c == 0, c == 2, c == 3, c == 4})
         rdx(PIN_FUNC_OFS, 8'(c << 2));
      end
      gatvr_host_inst.wr(AUDIO_SLOT_OFS, 8'hD5);
      settle();
      `CHK({audioSlotBits, audioTxEnable, audioSlot}, {SLOT_LEN_LONG, 1'b1, 6'h15})
      gatvr_host_inst.wr(AUDIO_SLOT_OFS, 8'h3F);
      settle();
      `CHK({audioSlotBits, audioTxEnable, audioSlot}, {SLOT_LEN_SHORT, 1'b0, 6'h3F})
      for (int n = 0; n < 8; n++) begin
         gatvr_host_inst.align(8'h03, 8'(1 << n));
         for (int q = 0; q < 3; q++) begin
            slotQuery = 6'(1 + 3 * n + q);
            settle();
            `CHK(slotInLimiterGroup, q == 0)
         end
      end
      foreach (volTbl[i]) begin
         d = (i == 0) ? xs() : volTbl[i];
         gatvr_host_inst.wr(VOLUME_OFS, d);
         settle();
         `CHK({volumeAttenHalfDb, volumeMute}, {d, d > 8'hC8})
      end
      gatvr_host_inst.align(8'hFD, 8'h81);
      {slotQuery} = 6'h3E;
      settle();
      `CHK({brownoutAlignEnable, limiterAlignEnable, alignStartSlot, slotInLimiterGroup},
         {1'b1, 1'b1, 6'h3E, 1'b1})
      `CHK(alignNoiseGateEnable, 1'b1)
      slotQuery = 6'h13;
      settle();
      `CHK(slotInLimiterGroup, 1'b0)
      gatvr_host_inst.align(8'h7C, 8'h81);
      slotQuery = 6'h3E;
      settle();
      `CHK({brownoutAlignEnable, limiterAlignEnable, slotInLimiterGroup}, 3'b000)
      for (int c = 0; c < 32; c++) begin
         {brownoutAtten, limiterAtten} = (c == 1) ? 16'hFFFF : {xs(), xs()};
         d = {1'b0, 2'(c), 5'(c)};
         gatvr_host_inst.wr(DIAG_CFG_OFS, d);
         settle();
         `CHK({diagClockExternal, diagActive}, {d[6], c != 0 && c < 15})
         `CHK(diagSignalSelect, (c < 15) ? 5'(c) : 5'h00)
         `CHK(appliedAtten, d[5] ? {1'b0, (brownoutAtten > limiterAtten) ? brownoutAtten
            : limiterAtten} : {1'b0, brownoutAtten} + {1'b0, limiterAtten})
      end
      gatvr_host_inst.wr(8'h1B, 8'hFF);
      rdx(8'h1B, 8'h00);
      rdx(PIN_FUNC_OFS, 8'h1C);
      settle();
      tally_and_finish();
   end
endmodule : testbench
bind gatvr_regs gatvr_regs_assertions gatvr_regs_chk (.clk(clk), .rstn(rstn),
   .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
   .regRdData(regRdData), .pinGainAlign(pinGainAlign), .pinGpOutput(pinGpOutput),
   .audioTxEnable(audioTxEnable), .audioSlotBits(audioSlotBits), .audioSlot(audioSlot),
   .brownoutAlignEnable(brownoutAlignEnable), .limiterAlignEnable(limiterAlignEnable),
   .alignStartSlot(alignStartSlot), .slotInLimiterGroup(slotInLimiterGroup),
   .diagClockExternal(diagClockExternal), .diagActive(diagActive),
   .diagSignalSelect(diagSignalSelect), .brownoutAtten(brownoutAtten),
   .limiterAtten(limiterAtten), .appliedAtten(appliedAtten),
   .volumeAttenHalfDb(volumeAttenHalfDb), .volumeMute(volumeMute));

// ### src/gatvr_pkg.sv
package gatvr_pkg;

   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] PIN_FUNC_OFS    = 8'h15;
   localparam logic [7:0] AUDIO_SLOT_OFS  = 8'h16;
   localparam logic [7:0] ALIGN_CFG_OFS   = 8'h17;
   localparam logic [7:0] ALIGN_MASK_OFS  = 8'h18;
   localparam logic [7:0] DIAG_CFG_OFS    = 8'h19;
   localparam logic [7:0] VOLUME_OFS      = 8'h1A;

   // ---------------------------------------------------------------
   // Reset values and writable-bit masks
   // ---------------------------------------------------------------
   localparam logic [7:0] PIN_FUNC_RST    = 8'h00;
   localparam logic [7:0] AUDIO_SLOT_RST  = 8'h12;
   localparam logic [7:0] ALIGN_CFG_RST   = 8'h0C;
   localparam logic [7:0] ALIGN_MASK_RST  = 8'h00;
   localparam logic [7:0] DIAG_CFG_RST    = 8'h0D;
   localparam logic [7:0] VOLUME_RST      = 8'h00;
   localparam logic [7:0] PIN_FUNC_WMASK  = 8'h1C;
   localparam logic [7:0] FULL_WMASK      = 8'hFF;
   localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int PIN_ROLE_LSB     = 2;
   localparam int PIN_ROLE_MSB     = 4;
   localparam int AUDIO_SLOT_LENGTH_BIT   = 7;
   localparam int AUDIO_TXEN_BIT   = 6;
   localparam int AUDIO_SLOT_MSB   = 5;
   localparam int BROWN_ALIGN_BIT  = 7;
   localparam int START_SLOT_MSB   = 6;
   localparam int START_SLOT_LSB   = 1;
   localparam int LIM_ALIGN_BIT    = 0;
   localparam int NG_ALIGN_BIT     = 7;
   localparam int DIAG_CLK_BIT     = 6;
   localparam int COMBINE_BIT      = 5;
   localparam int DIAG_SIG_MSB     = 4;

   // ---------------------------------------------------------------
   // Encodings
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PIN_GAIN_ALIGN  = 3'b000,
      PIN_RSVD1       = 3'b001,
      PIN_BUF_OFF     = 3'b010,
      PIN_GP_INPUT    = 3'b011,
      PIN_GP_OUTPUT   = 3'b100
   } gatvr_pin_role_type;

   localparam logic [4:0] DIAG_IDLE       = 5'h00;
   localparam logic [4:0] DIAG_SINE_1K    = 5'h0D;
   localparam logic [4:0] DIAG_PROG_DC    = 5'h0E;
   localparam logic [4:0] DIAG_RSVD_FIRST = 5'h0F;

   localparam logic [4:0] SLOT_LEN_SHORT  = 5'h10;   // 16-bit slot
   localparam logic [4:0] SLOT_LEN_LONG   = 5'h18;   // 24-bit slot
   localparam logic [6:0] SLOT_STRIDE     = 7'h03;
   localparam int         MASK_WIDTH      = 8;
   localparam logic [7:0] VOLUME_MAX_CODE = 8'hC8;

endpackage : gatvr_pkg

// ### src/gatvr_reg_cell.sv
`timescale 1ns/1ps
// One 8-bit configuration register; bits outside the write mask stay zero
module gatvr_reg_cell #(
   parameter logic [7:0] RESET_VALUE = 8'h00,
   parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
   input  wire logic       clk,
   input  wire logic       rstn,
   input  wire logic       wrEn,
   input  wire logic [7:0] wrData,
   output logic      [7:0] value
);

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   // Reserved bits ignore writes and hold zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         value <= RESET_VALUE & WRITE_MASK;
      end else if (wrEn) begin
         value <= wrData & WRITE_MASK;   // [RULE_13]
      end
   end

endmodule : gatvr_reg_cell

// ### src/gatvr_regs.sv
`timescale 1ns/1ps
// Behaviour
// [RULE_01] Pin-role field selects interchip pin function
// [RULE_02] Slot-length bit picks 16 or 24 bits
// [RULE_03] Audio transmit only when enabled, slot field
// [RULE_04] Brownout alignment only when its enable set
// [RULE_05] Six-bit align start slot, reset value six
// [RULE_06] Limiter alignment only when its enable set
// [RULE_07] Mask bit n adds slot start plus 3n
// [RULE_08] Software sets noise-gate alignment with gain alignment
// [RULE_09] Diagnostic clock: internal oscillator or serial clocks
// [RULE_10] Attenuation combine: sum, or larger of two
// [RULE_11] Diagnostic field selects test source; reserved idle
// [RULE_12] Volume 0.5 dB steps, mute above 0xC8
// [RULE_13] Reserved bits read zero, writes ignored
module gatvr_regs
   import gatvr_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rstn,
   // Register port
   input  wire logic [7:0] regAddr,
   input  wire logic       regWrEn,
   input  wire logic [7:0] regWrData,
   input  wire logic       regRdEn,
   output logic      [7:0] regRdData,
   // Interchip pin role
   output logic            pinGainAlign,
   output logic            pinBuffersOff,
   output logic            pinGpInput,
   output logic            pinGpOutput,
   // Returned audio slot
   output logic            audioTxEnable,
   output logic      [4:0] audioSlotBits,
   output logic      [5:0] audioSlot,
   // Gain alignment
   output logic            brownoutAlignEnable,
   output logic            limiterAlignEnable,
   output logic      [5:0] alignStartSlot,
   output logic            alignNoiseGateEnable,
   input  wire logic [5:0] slotQuery,
   output logic            slotInLimiterGroup,
   // Diagnostic generator
   output logic            diagClockExternal,
   output logic            diagActive,
   output logic      [4:0] diagSignalSelect,
   // Attenuation combine
   input  wire logic [7:0] brownoutAtten,
   input  wire logic [7:0] limiterAtten,
   output logic      [8:0] appliedAtten,
   // Digital volume
   output logic      [7:0] volumeAttenHalfDb,
   output logic            volumeMute
);

   // ---------------------------------------------------------------
   // Write decode
   // ---------------------------------------------------------------
   logic       wrPinFunc;
   logic       wrAudioSlot;
   logic       wrAlignCfg;
   logic       wrAlignMask;
   logic       wrDiagCfg;
   logic       wrVolume;
   logic [7:0] pinFuncReg;
   logic [7:0] audioSlotReg;
   logic [7:0] alignCfgReg;
   logic [7:0] alignMaskReg;
   logic [7:0] diagCfgReg;
   logic [7:0] volumeReg;

   // One strobe per register, address chain
   always_comb begin
      wrPinFunc   = 1'b0;
      wrAudioSlot = 1'b0;
      wrAlignCfg  = 1'b0;
      wrAlignMask = 1'b0;
      wrDiagCfg   = 1'b0;
      wrVolume    = 1'b0;
      if (regWrEn) begin
         if (regAddr == PIN_FUNC_OFS) begin
            wrPinFunc = 1'b1;
         end else if (regAddr == AUDIO_SLOT_OFS) begin
            wrAudioSlot = 1'b1;
         end else if (regAddr == ALIGN_CFG_OFS) begin
            wrAlignCfg = 1'b1;
         end else if (regAddr == ALIGN_MASK_OFS) begin
            wrAlignMask = 1'b1;
         end else if (regAddr == DIAG_CFG_OFS) begin
            wrDiagCfg = 1'b1;
         end else if (regAddr == VOLUME_OFS) begin
            wrVolume = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Register storage
   // ---------------------------------------------------------------
   // Pin function keeps only the role field writable
   gatvr_reg_cell #(
      .RESET_VALUE (PIN_FUNC_RST),
      .WRITE_MASK  (PIN_FUNC_WMASK)
   ) uPinFunc (
      .clk    (clk),
      .rstn   (rstn),
      .wrEn   (wrPinFunc),
      .wrData (regWrData),
      .value  (pinFuncReg)
   );

   gatvr_reg_cell #(
      .RESET_VALUE (AUDIO_SLOT_RST),
      .WRITE_MASK  (FULL_WMASK)
   ) uAudioSlot (
      .clk    (clk),
      .rstn   (rstn),
      .wrEn   (wrAudioSlot),
      .wrData (regWrData),
      .value  (audioSlotReg)
   );

   gatvr_reg_cell #(
      .RESET_VALUE (ALIGN_CFG_RST),
      .WRITE_MASK  (FULL_WMASK)
   ) uAlignCfg (
      .clk    (clk),
      .rstn   (rstn),
      .wrEn   (wrAlignCfg),
      .wrData (regWrData),
      .value  (alignCfgReg)
   );

   gatvr_reg_cell #(
      .RESET_VALUE (ALIGN_MASK_RST),
      .WRITE_MASK  (FULL_WMASK)
   ) uAlignMask (
      .clk    (clk),
      .rstn   (rstn),
      .wrEn   (wrAlignMask),
      .wrData (regWrData),
      .value  (alignMaskReg)
   );

   gatvr_reg_cell #(
      .RESET_VALUE (DIAG_CFG_RST),
      .WRITE_MASK  (FULL_WMASK)
   ) uDiagCfg (
      .clk    (clk),
      .rstn   (rstn),
      .wrEn   (wrDiagCfg),
      .wrData (regWrData),
      .value  (diagCfgReg)
   );

   gatvr_reg_cell #(
      .RESET_VALUE (VOLUME_RST),
      .WRITE_MASK  (FULL_WMASK)
   ) uVolume (
      .clk    (clk),
      .rstn   (rstn),
      .wrEn   (wrVolume),
      .wrData (regWrData),
      .value  (volumeReg)
   );

   // ---------------------------------------------------------------
   // Read path
   // ---------------------------------------------------------------
   logic [7:0] rdData_nxt;

   // Unmapped offsets read zero
   always_comb begin
      if (regAddr == PIN_FUNC_OFS) begin
         rdData_nxt = pinFuncReg;   // [RULE_13]
      end else if (regAddr == AUDIO_SLOT_OFS) begin
         rdData_nxt = audioSlotReg;
      end else if (regAddr == ALIGN_CFG_OFS) begin
         rdData_nxt = alignCfgReg;
      end else if (regAddr == ALIGN_MASK_OFS) begin
         rdData_nxt = alignMaskReg;
      end else if (regAddr == DIAG_CFG_OFS) begin
         rdData_nxt = diagCfgReg;
      end else if (regAddr == VOLUME_OFS) begin
         rdData_nxt = volumeReg;
      end else begin
         rdData_nxt = UNMAPPED_DATA;
      end
   end

   // Read data held until the next read
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regRdData <= UNMAPPED_DATA;
      end else if (regRdEn) begin
         regRdData <= rdData_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Interchip pin role
   // ---------------------------------------------------------------
   gatvr_pin_role_type pinRole;

   assign pinRole = gatvr_pin_role_type'(pinFuncReg[PIN_ROLE_MSB:PIN_ROLE_LSB]);

   // One-hot role; reserved codes select no role
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pinGainAlign  <= 1'b1;
         pinBuffersOff <= 1'b0;
         pinGpInput    <= 1'b0;
         pinGpOutput   <= 1'b0;
      end else begin
         pinGainAlign  <= (pinRole == PIN_GAIN_ALIGN);   // [RULE_01]
         pinBuffersOff <= (pinRole == PIN_BUF_OFF);      // [RULE_01]
         pinGpInput    <= (pinRole == PIN_GP_INPUT);     // [RULE_01]
         pinGpOutput   <= (pinRole == PIN_GP_OUTPUT);    // [RULE_01]
      end
   end

   // ---------------------------------------------------------------
   // Returned audio slot
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         audioTxEnable <= 1'b0;
         audioSlotBits <= SLOT_LEN_SHORT;
         audioSlot     <= AUDIO_SLOT_RST[AUDIO_SLOT_MSB:0];
      end else begin
         audioTxEnable <= audioSlotReg[AUDIO_TXEN_BIT];                 // [RULE_03]
         audioSlotBits <= audioSlotReg[AUDIO_SLOT_LENGTH_BIT] ? SLOT_LEN_LONG
                                                       : SLOT_LEN_SHORT; // [RULE_02]
         audioSlot     <= audioSlotReg[AUDIO_SLOT_MSB:0];                // [RULE_03]
      end
   end

   // ---------------------------------------------------------------
   // Gain alignment
   // ---------------------------------------------------------------
   logic inGroup_nxt;

   // Slot n of the group is start plus stride times n
   always_comb begin
      logic [6:0] memberSlot;
      memberSlot  = 7'h00;
      inGroup_nxt = 1'b0;
      for (int n = 0; n < MASK_WIDTH; n++) begin
         memberSlot = {1'b0, alignCfgReg[START_SLOT_MSB:START_SLOT_LSB]}
                      + 7'(SLOT_STRIDE * 7'(n));                          // [RULE_07]
         if (alignMaskReg[n] && memberSlot == {1'b0, slotQuery}) begin
            inGroup_nxt = 1'b1;                                          // [RULE_07]
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         brownoutAlignEnable  <= 1'b0;
         limiterAlignEnable   <= 1'b0;
         alignStartSlot       <= ALIGN_CFG_RST[START_SLOT_MSB:START_SLOT_LSB];
         alignNoiseGateEnable <= 1'b0;
         slotInLimiterGroup   <= 1'b0;
      end else begin
         brownoutAlignEnable  <= alignCfgReg[BROWN_ALIGN_BIT];               // [RULE_04]
         limiterAlignEnable   <= alignCfgReg[LIM_ALIGN_BIT];                 // [RULE_06]
         alignStartSlot       <= alignCfgReg[START_SLOT_MSB:START_SLOT_LSB]; // [RULE_05]
         alignNoiseGateEnable <= diagCfgReg[NG_ALIGN_BIT];                   // [RULE_08]
         slotInLimiterGroup   <= alignCfgReg[LIM_ALIGN_BIT] & inGroup_nxt;   // [RULE_06]
      end
   end

   // ---------------------------------------------------------------
   // Diagnostic generator and attenuation combine
   // ---------------------------------------------------------------
   logic [4:0] diagSel;

   assign diagSel = diagCfgReg[DIAG_SIG_MSB:0];

   // Reserved source codes fall back to idle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         diagClockExternal <= 1'b0;
         diagActive        <= 1'b1;
         diagSignalSelect  <= DIAG_SINE_1K;
         appliedAtten      <= 9'h000;
      end else begin
         diagClockExternal <= diagCfgReg[DIAG_CLK_BIT];                 // [RULE_09]
         if (diagSel >= DIAG_RSVD_FIRST) begin
            diagActive       <= 1'b0;                                   // [RULE_11]
            diagSignalSelect <= DIAG_IDLE;
         end else begin
            diagActive       <= (diagSel != DIAG_IDLE);                 // [RULE_11]
            diagSignalSelect <= diagSel;
         end
         if (diagCfgReg[COMBINE_BIT]) begin
            appliedAtten <= (brownoutAtten > limiterAtten) ? {1'b0, brownoutAtten}
                                                           : {1'b0, limiterAtten}; // [RULE_10]
         end else begin
            appliedAtten <= {1'b0, brownoutAtten} + {1'b0, limiterAtten};        // [RULE_10]
         end
      end
   end

   // ---------------------------------------------------------------
   // Digital volume
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         volumeAttenHalfDb <= VOLUME_RST;
         volumeMute        <= 1'b0;
      end else begin
         volumeAttenHalfDb <= volumeReg;                                // [RULE_12]
         volumeMute        <= (volumeReg > VOLUME_MAX_CODE);            // [RULE_12]
      end
   end

endmodule : gatvr_regs
